// *** logic/ppmsi_top.sv ***
/*
  ppmsi_top: pin function select for port 3 and port 4, port 3 pull-ups,
  port 4 data and direction, serial pin control with data inversion.
  Assumes one 20 MHz clock, synchronous active-high reset, pins sampled
  synchronously, and a register master that never waits.
*/
// How it works
// - high timer select 1 drives timer high out on port3 bit2, else direction.
// - low timer select 1 drives timer low out on port3 bit1, else direction.
// - port3 pull-up on only when direction is 0 and pull-up bit 1.
// - all port3 pull-ups off after reset.
// - port4 data read returns stored bit where direction is 1.
// - port4 data read returns pin level where direction is 0.
// - port4 data bits 7..4 read 1, bit3 read-only, bits 2..0 reset 0.
// - port4 direction 1 makes output, 0 input, reset 0.
// - port4 direction is write-only and reads all ones.
// - port4 direction and data only act while the pin is general I/O.
// - transmit pin select bit5, together with transmitter enable, picks serial transmit for port4 bit2, reset 0.
// - bit3 inverts serial transmit output when 1, reset 0.
// - bit2 inverts serial receive input when 1, reset 0.
// - serial control bits 7 and 6 read 1 and ignore writes.
// - inversion changes act at once on the live data path.
// - port4 bit3 is plain input, or interrupt 0 input when selected.
// - port4 bit2 is transmit output when select and enable both 1.
`timescale 1ns/1ps
`default_nettype none

module ppmsi_top (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire ppmsi_pkg::ppmsi_req_t req,
  output logic [7:0]                 rdata,
  input  wire logic [7:1]            p3_pin_in,
  output logic [7:1]                 p3_pin_out,
  output logic [7:1]                 p3_pin_oe,
  output logic [7:1]                 p3_pullup_on,
  input  wire logic                  timer_high_out,
  input  wire logic                  timer_low_out,
  input  wire logic [3:0]            p4_pin_in,
  output ppmsi_pkg::ppmsi_p4_drv_t   p4_drv,
  input  wire logic                  transmitter_enable_bit,
  input  wire logic                  receive_enable_bit,
  input  wire logic                  serial_txd,
  output logic                       serial_rxd,
  output logic                       external_interrupt_zero_n
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [7:1] p3_data_q,   p3_data_d;
  logic [7:1] p3_dir_q,    p3_dir_d;
  logic [7:1] p3_pu_q,     p3_pu_d;
  logic [2:1] p3_mode_q,   p3_mode_d;
  logic [2:0] p4_data_q,   p4_data_d;
  logic [2:0] p4_dir_q,    p4_dir_d;
  logic       tx_sel_q,    tx_sel_d;
  logic       tx_inv_q,    tx_inv_d;
  logic       rx_inv_q,    rx_inv_d;
  logic       int0_sel_q,  int0_sel_d;
  logic [7:0] rdata_q,     rdata_d;

  logic       wr_p3_data;
  logic       wr_p3_dir;
  logic       wr_p3_pu;
  logic       wr_p3_mode;
  logic       wr_p4_data;
  logic       wr_p4_dir;
  logic       wr_spc;
  logic       wr_p2_mode;
  logic       tx_mode;
  logic [2:0] p4_gpio;
  logic [2:0] p4_read;
  logic [7:1] p3_read;

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  assign wr_p3_data = req.wr && (req.addr == ppmsi_pkg::OFF_PORT3_DATA);
  assign wr_p3_dir  = req.wr && (req.addr == ppmsi_pkg::OFF_PORT3_DIRECTION);
  assign wr_p3_pu   = req.wr && (req.addr == ppmsi_pkg::OFF_PORT3_PULLUP);
  assign wr_p3_mode = req.wr && (req.addr == ppmsi_pkg::OFF_PORT3_MODE);
  assign wr_p4_data = req.wr && (req.addr == ppmsi_pkg::OFF_PORT4_DATA);
  assign wr_p4_dir  = req.wr && (req.addr == ppmsi_pkg::OFF_PORT4_DIRECTION);
  assign wr_spc     = req.wr && (req.addr == ppmsi_pkg::OFF_SERIAL_PIN_CTRL);
  assign wr_p2_mode = req.wr && (req.addr == ppmsi_pkg::OFF_PORT2_MODE);

  // ----------------------------------------------------------------
  // pin function select
  // ----------------------------------------------------------------
  // port4 bit2 leaves general I/O only when both serial bits are set
  assign tx_mode = tx_sel_q && transmitter_enable_bit;
  // which port4 pins are still general I/O; bit1 yields to the receiver
  assign p4_gpio = {~tx_mode, ~receive_enable_bit, 1'b1};

  // port3 pins: timer outputs override direction on bits 2 and 1
  always_comb begin
    p3_pin_out = p3_data_q;
    p3_pin_oe  = p3_dir_q;
    if (p3_mode_q[ppmsi_pkg::BIT_TIMER_HIGH_SEL]) begin
      p3_pin_out[2] = timer_high_out;
      p3_pin_oe[2]  = 1'b1;
    end
    if (p3_mode_q[ppmsi_pkg::BIT_TIMER_LOW_SEL]) begin
      p3_pin_out[1] = timer_low_out;
      p3_pin_oe[1]  = 1'b1;
    end
  end

  // pull-up only on a pin whose direction bit is 0 with its pull-up bit set, even while a timer drives it
  assign p3_pullup_on = ~p3_dir_q & p3_pu_q;

  // port4 drivers; transmit path inverted live, no register in between
  always_comb begin
    p4_drv.out = p4_data_q;
    p4_drv.oe  = p4_dir_q & p4_gpio;
    if (tx_mode) begin
      p4_drv.out[2] = serial_txd ^ tx_inv_q;
      p4_drv.oe[2]  = 1'b1;
    end
  end

  assign serial_rxd = p4_pin_in[1] ^ rx_inv_q;

  // interrupt line idles high while the pin is a plain input
  assign external_interrupt_zero_n = int0_sel_q ? p4_pin_in[3] : 1'b1;

  // ----------------------------------------------------------------
  // read view of the ports
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      p4_read[i] = p4_dir_q[i] ? p4_data_q[i] : p4_pin_in[i];
    end
    for (int j = 1; j < 8; j++) begin
      p3_read[j] = p3_dir_q[j] ? p3_data_q[j] : p3_pin_in[j];
    end
  end

  // ----------------------------------------------------------------
  // next register values and read mux
  // ----------------------------------------------------------------
  always_comb begin
    p3_data_d  = wr_p3_data ? req.wdata[7:1] : p3_data_q;
    p3_dir_d   = wr_p3_dir  ? req.wdata[7:1] : p3_dir_q;
    p3_pu_d    = wr_p3_pu   ? req.wdata[7:1] : p3_pu_q;
    p3_mode_d  = wr_p3_mode ? req.wdata[2:1] : p3_mode_q;
    p4_data_d  = wr_p4_data ? req.wdata[2:0] : p4_data_q;
    p4_dir_d   = wr_p4_dir  ? req.wdata[2:0] : p4_dir_q;
    tx_sel_d   = wr_spc ? req.wdata[ppmsi_pkg::BIT_TX_PIN_SELECT] : tx_sel_q;
    tx_inv_d   = wr_spc ? req.wdata[ppmsi_pkg::BIT_TX_INVERT] : tx_inv_q;
    rx_inv_d   = wr_spc ? req.wdata[ppmsi_pkg::BIT_RX_INVERT] : rx_inv_q;
    int0_sel_d = wr_p2_mode ? req.wdata[ppmsi_pkg::BIT_EXT_INT0_SELECT] : int0_sel_q;
    rdata_d    = ppmsi_pkg::RD_ZERO;
    if (req.rd) begin
      case (req.addr)
        ppmsi_pkg::OFF_PORT3_DATA:      rdata_d = {p3_read, 1'b0};
        ppmsi_pkg::OFF_PORT3_DIRECTION: rdata_d = ppmsi_pkg::RD_ALL_ONES;
        ppmsi_pkg::OFF_PORT3_PULLUP:    rdata_d = {p3_pu_q, 1'b0};
        ppmsi_pkg::OFF_PORT3_MODE:      rdata_d = {5'h00, p3_mode_q, 1'b0};
        ppmsi_pkg::OFF_PORT4_DATA:
          rdata_d = {ppmsi_pkg::RD_P4_RESERVED, p4_pin_in[3], p4_read};
        ppmsi_pkg::OFF_PORT4_DIRECTION: rdata_d = ppmsi_pkg::RD_ALL_ONES;
        ppmsi_pkg::OFF_SERIAL_PIN_CTRL:
          rdata_d = {ppmsi_pkg::RD_SPC_RESERVED, tx_sel_q, 1'b0,
                     tx_inv_q, rx_inv_q, 2'h0};
        ppmsi_pkg::OFF_PORT2_MODE:
          rdata_d = ppmsi_pkg::RD_P2_RESERVED | {7'h00, int0_sel_q};
        default:                        rdata_d = ppmsi_pkg::RD_ZERO;
      endcase
    end
  end

  // register stage; every control takes the write on its own edge
  always_ff @(posedge clk) begin
    if (rst) begin
      p3_data_q  <= ppmsi_pkg::RST_PORT3_DATA;
      p3_dir_q   <= ppmsi_pkg::RST_PORT3_DIR;
      p3_pu_q    <= ppmsi_pkg::RST_PORT3_PULLUP;
      p3_mode_q  <= ppmsi_pkg::RST_PORT3_MODE;
      p4_data_q  <= ppmsi_pkg::RST_PORT4_DATA;
      p4_dir_q   <= ppmsi_pkg::RST_PORT4_DIR;
      tx_sel_q   <= ppmsi_pkg::RST_SPC_BITS[2];
      tx_inv_q   <= ppmsi_pkg::RST_SPC_BITS[1];
      rx_inv_q   <= ppmsi_pkg::RST_SPC_BITS[0];
      int0_sel_q <= ppmsi_pkg::RST_INT0_SELECT;
      rdata_q    <= ppmsi_pkg::RD_ZERO;
    end else begin
      p3_data_q  <= p3_data_d;
      p3_dir_q   <= p3_dir_d;
      p3_pu_q    <= p3_pu_d;
      p3_mode_q  <= p3_mode_d;
      p4_data_q  <= p4_data_d;
      p4_dir_q   <= p4_dir_d;
      tx_sel_q   <= tx_sel_d;
      tx_inv_q   <= tx_inv_d;
      rx_inv_q   <= rx_inv_d;
      int0_sel_q <= int0_sel_d;
      rdata_q    <= rdata_d;
    end
  end

  assign rdata = rdata_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_rd_p4data;
    req.rd && (req.addr == ppmsi_pkg::OFF_PORT4_DATA);
  endsequence

  sequence s_wr_p4dir;
    req.wr && (req.addr == ppmsi_pkg::OFF_PORT4_DIRECTION) && !receive_enable_bit;
  endsequence

  sequence s_wr_spc_tx;
    req.wr && (req.addr == ppmsi_pkg::OFF_SERIAL_PIN_CTRL);
  endsequence

  property p_timer_high;
    (req.wr && req.addr == ppmsi_pkg::OFF_PORT3_MODE && req.wdata[2]) |=>
      (p3_pin_oe[2] && p3_pin_out[2] == timer_high_out);
  endproperty
  a_timer_high: assert property (p_timer_high)
    else $error("port3 bit2 not driving timer high output");

  property p_timer_low;
    !p3_mode_q[1] |-> (p3_pin_oe[1] == p3_dir_q[1]);
  endproperty
  a_timer_low: assert property (p_timer_low)
    else $error("port3 bit1 not following its direction bit");

  property p_pullup;
    (req.wr && req.addr == ppmsi_pkg::OFF_PORT3_PULLUP) |=>
      (p3_pullup_on == ($past(req.wdata[7:1]) & ~p3_dir_q));
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("pull-up state wrong after write");

  property p_pullup_reset;
    @(posedge clk) disable iff (1'b0) rst |=> (p3_pullup_on == 7'h00);
  endproperty
  a_pullup_reset: assert property (p_pullup_reset)
    else $error("pull-up on after reset");

  property p_p4_read;
    s_rd_p4data |=> (rdata[7:4] == 4'hf) &&
      (rdata[2:0] == (($past(p4_dir_q) & $past(p4_data_q)) |
                      (~$past(p4_dir_q) & $past(p4_pin_in[2:0]))));
  endproperty
  a_p4_read: assert property (p_p4_read)
    else $error("port4 data read value wrong");

  property p_p4dir_read;
    (req.rd && req.addr == ppmsi_pkg::OFF_PORT4_DIRECTION) |=> (rdata == 8'hff);
  endproperty
  a_p4dir_read: assert property (p_p4dir_read)
    else $error("port4 direction read not all ones");

  property p_p4dir_write;
    s_wr_p4dir ##0 (req.wdata[0] == 1'b1) |=>
      p4_drv.oe[0] ##1 (p4_drv.oe[0] || $changed(p4_dir_q));
  endproperty
  a_p4dir_write: assert property (p_p4dir_write)
    else $error("port4 bit0 not output after direction write");

  property p_spc_reserved;
    (req.rd && req.addr == ppmsi_pkg::OFF_SERIAL_PIN_CTRL) |=>
      (rdata[7:6] == 2'h3 && rdata[4] == 1'b0 && rdata[1:0] == 2'h0);
  endproperty
  a_spc_reserved: assert property (p_spc_reserved)
    else $error("serial control reserved bits read wrong");

  property p_tx_path;
    (tx_sel_q && transmitter_enable_bit) |->
      (p4_drv.oe[2] && p4_drv.out[2] == (serial_txd ^ tx_inv_q));
  endproperty
  a_tx_path: assert property (p_tx_path)
    else $error("transmit pin not driven by inverted serial data");

  property p_inv_immediate;
    s_wr_spc_tx |=> (serial_rxd == (p4_pin_in[1] ^ $past(req.wdata[2])));
  endproperty
  a_inv_immediate: assert property (p_inv_immediate)
    else $error("receive inversion not applied on next edge");

  property p_int0;
    !int0_sel_q |-> external_interrupt_zero_n;
  endproperty
  a_int0: assert property (p_int0)
    else $error("interrupt line active while pin is plain input");

  // port4 data read: reserved nibble fixed high, bit3 is the live pin
  property p_p4_fixed_bits;
    s_rd_p4data |=> (rdata[7:4] == ppmsi_pkg::RD_P4_RESERVED) &&
      (rdata[3] == $past(p4_pin_in[3]));
  endproperty
  a_p4_fixed_bits: assert property (p_p4_fixed_bits)
    else $error("port4 data reserved or bit3 read wrong");

  // with every pin an input the read is the pin picture itself
  property p_p4_pin_read;
    s_rd_p4data ##0 (p4_dir_q == 3'h0) |=> (rdata[2:0] == $past(p4_pin_in[2:0]));
  endproperty
  a_p4_pin_read: assert property (p_p4_pin_read)
    else $error("port4 input pins not read as pin levels");

  // reset leaves port4 undriven and the serial controls cleared
  property p_p4_reset;
    @(posedge clk) disable iff (1'b0) rst |=> (p4_drv == 6'h00);
  endproperty
  a_p4_reset: assert property (p_p4_reset)
    else $error("port4 driven after reset");

  property p_spc_reset;
    @(posedge clk) disable iff (1'b0) rst |=>
      (!tx_sel_q && !tx_inv_q && !rx_inv_q);
  endproperty
  a_spc_reset: assert property (p_spc_reset)
    else $error("serial pin control not cleared by reset");

  // transmit output inverted when the inversion bit is set and port4 bit2 is in transmit mode
  property p_tx_invert;
    (tx_sel_q && transmitter_enable_bit && tx_inv_q) |-> (p4_drv.out[2] == !serial_txd);
  endproperty
  a_tx_invert: assert property (p_tx_invert)
    else $error("transmit pin not inverted");

  // receiver owns port4 bit1 while it runs
  property p_rx_owns_pin;
    receive_enable_bit |-> !p4_drv.oe[1];
  endproperty
  a_rx_owns_pin: assert property (p_rx_owns_pin)
    else $error("port4 bit1 driven while receiver enabled");

  // without both serial bits the transmit pin is plain general I/O
  property p_tx_pin_gpio;
    !(tx_sel_q && transmitter_enable_bit) |->
      (p4_drv.oe[2] == p4_dir_q[2]) && (p4_drv.out[2] == p4_data_q[2]);
  endproperty
  a_tx_pin_gpio: assert property (p_tx_pin_gpio)
    else $error("port4 bit2 not following its direction bit");

  // a direction write lands on the edge that takes it
  sequence s_wr_p4dir_all;
    req.wr && (req.addr == ppmsi_pkg::OFF_PORT4_DIRECTION);
  endsequence

  property p_dir_edge;
    s_wr_p4dir_all |=> (p4_dir_q == $past(req.wdata[2:0]));
  endproperty
  a_dir_edge: assert property (p_dir_edge)
    else $error("direction write not taken on its edge");

  // no pull-up on a pin whose direction bit is 1
  property p_pullup_dir;
    (p3_pullup_on & p3_dir_q) == 7'h00;
  endproperty
  a_pullup_dir: assert property (p_pullup_dir)
    else $error("pull-up on while pin is an output");

  // selected interrupt input follows the pin level
  property p_int0_follow;
    int0_sel_q |-> (external_interrupt_zero_n == p4_pin_in[3]);
  endproperty
  a_int0_follow: assert property (p_int0_follow)
    else $error("interrupt line not following its pin");

  property p_timer_low_drive;
    (req.wr && req.addr == ppmsi_pkg::OFF_PORT3_MODE && req.wdata[1]) |=>
      (p3_pin_oe[1] && p3_pin_out[1] == timer_low_out);
  endproperty
  a_timer_low_drive: assert property (p_timer_low_drive)
    else $error("port3 bit1 not driving timer low output");

  property p_timer_high_off;
    !p3_mode_q[2] |-> (p3_pin_oe[2] == p3_dir_q[2]);
  endproperty
  a_timer_high_off: assert property (p_timer_high_off)
    else $error("port3 bit2 not following its direction bit");

endmodule : ppmsi_top

`default_nettype wire

// *** logic/ppmsi_pkg.sv ***
/*
  ppmsi_pkg: shared constants and carrier types of the port pin mux block.
  Assumes a byte-wide register port with a 3-bit word address.
*/
`default_nettype none

package ppmsi_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [2:0] OFF_PORT3_DATA      = 3'h0;
  localparam logic [2:0] OFF_PORT3_DIRECTION = 3'h1;
  localparam logic [2:0] OFF_PORT3_PULLUP    = 3'h2;
  localparam logic [2:0] OFF_PORT3_MODE      = 3'h3;
  localparam logic [2:0] OFF_PORT4_DATA      = 3'h4;
  localparam logic [2:0] OFF_PORT4_DIRECTION = 3'h5;
  localparam logic [2:0] OFF_SERIAL_PIN_CTRL = 3'h6;
  localparam logic [2:0] OFF_PORT2_MODE      = 3'h7;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned BIT_TIMER_HIGH_SEL  = 2;  // port3 mode
  localparam int unsigned BIT_TIMER_LOW_SEL   = 1;  // port3 mode
  localparam int unsigned BIT_TX_PIN_SELECT   = 5;  // serial pin control
  localparam int unsigned BIT_TX_INVERT       = 3;  // serial pin control
  localparam int unsigned BIT_RX_INVERT       = 2;  // serial pin control
  localparam int unsigned BIT_EXT_INT0_SELECT = 0;  // port2 mode

  // ----------------------------------------------------------------
  // reset values and fixed read patterns
  // ----------------------------------------------------------------
  localparam logic [7:1] RST_PORT3_DATA   = 7'h00;
  localparam logic [7:1] RST_PORT3_DIR    = 7'h00;
  localparam logic [7:1] RST_PORT3_PULLUP = 7'h00;
  localparam logic [2:1] RST_PORT3_MODE   = 2'h0;
  localparam logic [2:0] RST_PORT4_DATA   = 3'h0;
  localparam logic [2:0] RST_PORT4_DIR    = 3'h0;
  localparam logic [2:0] RST_SPC_BITS     = 3'h0;  // select, tx inv, rx inv
  localparam logic       RST_INT0_SELECT  = 1'b0;
  localparam logic [7:0] RD_ALL_ONES      = 8'hff;
  localparam logic [7:0] RD_ZERO          = 8'h00;
  localparam logic [3:0] RD_P4_RESERVED   = 4'hf;  // port4 data bits 7..4
  localparam logic [1:0] RD_SPC_RESERVED  = 2'h3;  // serial ctrl bits 7..6
  localparam logic [7:0] RD_P2_RESERVED   = 8'hd8; // port2 mode bits 7,6,4,3

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ppmsi_req_t;

  typedef struct packed {
    logic [2:0] out;
    logic [2:0] oe;
  } ppmsi_p4_drv_t;

endpackage : ppmsi_pkg

`default_nettype wire

// *** test/ppmsi_pins_model.sv ***
/*
  ppmsi_pins_model: the board and outside world seen from the port pins.
  Assumes the bench gives outside driver levels and their enables.
*/
`timescale 1ns/1ps
`default_nettype none

module ppmsi_pins_model (
  input  wire logic                     clk,
  input  wire logic [7:1]               p3_ext,
  input  wire logic [7:1]               p3_ext_en,
  input  wire logic [7:1]               p3_pin_out,
  input  wire logic [7:1]               p3_pin_oe,
  input  wire logic [7:1]               p3_pullup_on,
  input  wire logic [3:0]               p4_ext,
  input  wire logic [3:0]               p4_ext_en,
  input  wire ppmsi_pkg::ppmsi_p4_drv_t p4_drv,
  output logic [7:1]                    p3_pin_in,
  output logic [3:0]                    p4_pin_in
);
  logic float_q = 1'b0;

  // a released line wanders every cycle so a stale level never passes
  always_ff @(posedge clk) begin
    float_q <= ~float_q;
  end

  // wire level: own driver first, then outside driver, pull-up, else floating
  always_comb begin
    for (int i = 1; i < 8; i++) begin
      if (p3_pin_oe[i]) begin
        p3_pin_in[i] = p3_pin_out[i];
      end else if (p3_ext_en[i]) begin
        p3_pin_in[i] = p3_ext[i];
      end else begin
        p3_pin_in[i] = p3_pullup_on[i] | float_q;
      end
    end
    for (int j = 0; j < 4; j++) begin
      if (j < 3 && p4_drv.oe[j % 3]) begin
        p4_pin_in[j] = p4_drv.out[j % 3];
      end else begin
        p4_pin_in[j] = p4_ext_en[j] ? p4_ext[j] : float_q;
      end
    end
  end
endmodule : ppmsi_pins_model

`default_nettype wire

// *** test/test_port_pin_mux_serial_invert.sv ***
/*
  test_port_pin_mux_serial_invert: self-checking bench of the pin mux block.
  Assumes ppmsi_pkg, ppmsi_top and ppmsi_pins_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module test_port_pin_mux_serial_invert;
  typedef struct packed {
    logic [2:0] wa;
    logic [7:0] wd;
    logic [2:0] ra;
    logic [7:0] exp;
  } ppmsi_row_t;

  logic                     clk = 1'b0;
  logic                     rst = 1'b1;
  ppmsi_pkg::ppmsi_req_t    req = '0;
  logic [7:0]               rdata, d;
  logic [7:1]               p3_in, p3_out, p3_oe, p3_pu;
  logic [3:0]               p4_in;
  logic [3:0]               p4_ext = 4'ha;
  ppmsi_pkg::ppmsi_p4_drv_t p4_drv;
  logic                     th = 1'b0, tl = 1'b0, te = 1'b0, txd = 1'b1, re = 1'b0;
  logic                     rxd, int_n;
  int                       n_mismatch = 0, n_checks = 0;
  ppmsi_row_t               rows [7];

  // ----------------------------------------------------------------
  // clock, design and pins
  // ----------------------------------------------------------------
  always #25 clk = ~clk;

  ppmsi_top i_dut (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .p3_pin_in(p3_in),
    .p3_pin_out(p3_out), .p3_pin_oe(p3_oe), .p3_pullup_on(p3_pu), .timer_high_out(th),
    .timer_low_out(tl), .p4_pin_in(p4_in), .p4_drv(p4_drv), .transmitter_enable_bit(te),
    .receive_enable_bit(re), .serial_txd(txd), .serial_rxd(rxd),
    .external_interrupt_zero_n(int_n));

  ppmsi_pins_model i_pins (.clk(clk), .p3_ext(7'h55), .p3_ext_en(7'h00), .p3_pin_out(p3_out),
    .p3_pin_oe(p3_oe), .p3_pullup_on(p3_pu), .p4_ext(p4_ext), .p4_ext_en(4'hf),
    .p4_drv(p4_drv), .p3_pin_in(p3_in), .p4_pin_in(p4_in));

  // ----------------------------------------------------------------
  // bus cycles, compare and closing
  // ----------------------------------------------------------------
  task automatic bus_wr(input logic [2:0] a, input logic [7:0] wd);
    @(posedge clk);
    req <= '{addr: a, wdata: wd, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '0;
    #1;
  endtask : bus_wr

  task automatic bus_rd(input logic [2:0] a, output logic [7:0] rd);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '0;
    #1;
    rd = rdata;
  endtask : bus_rd

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  // ----------------------------------------------------------------
  // watchdog against a hang
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rows[0] = '{3'h6, 8'h2c, 3'h6, 8'hec};  // reserved top bits stay 1
    rows[1] = '{3'h6, 8'h00, 3'h6, 8'hc0};
    rows[2] = '{3'h5, 8'h07, 3'h5, 8'hff};  // direction reads all ones
    rows[3] = '{3'h4, 8'h05, 3'h4, 8'hfd};  // outputs read stored data
    rows[4] = '{3'h5, 8'h00, 3'h4, 8'hfa};  // inputs read pin levels
    rows[5] = '{3'h7, 8'h01, 3'h7, 8'hd9};
    rows[6] = '{3'h7, 8'h00, 3'h7, 8'hd8};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    // reset state of registers and pins
    bus_rd(3'h4, d);
    check("port4 data", 8'hfa, d);
    bus_rd(3'h6, d);
    check("serial ctrl", 8'hc0, d);
    check("p3 pullups", 8'h00, {1'b0, p3_pu});
    check("p4 drive", 8'h00, {2'b00, p4_drv});
    // table of write then read cases
    foreach (rows[i]) begin
      bus_wr(rows[i].wa, rows[i].wd);
      bus_rd(rows[i].ra, d);
      check("table read", rows[i].exp, d);
    end
    // port3 pull-ups and timer output select
    bus_wr(3'h2, 8'hfe);
    check("p3 pullups", 8'h7f, {1'b0, p3_pu});
    bus_wr(3'h1, 8'h0a);
    check("p3 pullups", 8'h7a, {1'b0, p3_pu});
    check("p3 enables", 8'h05, {1'b0, p3_oe});
    // bit1 data high so a missing timer low override shows up
    bus_wr(3'h0, 8'h02);
    @(posedge clk) th <= 1'b1;
    bus_wr(3'h3, 8'h06);
    check("p3 enables", 8'h07, {1'b0, p3_oe});
    check("p3 timer out", 8'h02, {6'h00, p3_out[2:1]});
    bus_wr(3'h1, 8'h00);
    check("p3 timer oe", 8'h03, {6'h00, p3_oe[2:1]});
    // transmit pin takeover and output inversion
    bus_wr(3'h5, 8'h04);
    bus_wr(3'h4, 8'h04);
    check("p4 drive", 8'h24, {2'b00, p4_drv});
    bus_wr(3'h6, 8'h20);
    check("p4 drive", 8'h24, {2'b00, p4_drv});
    @(posedge clk) te <= 1'b1;
    txd <= 1'b0;
    bus_wr(3'h4, 8'h00);
    check("p4 tx drive", 8'h04, {2'b00, p4_drv});
    bus_wr(3'h6, 8'h28);
    check("p4 tx drive", 8'h24, {2'b00, p4_drv});
    @(posedge clk) txd <= 1'b1;
    #1;
    check("p4 tx drive", 8'h04, {2'b00, p4_drv});
    // enable alone must not hand the pin to the transmitter
    bus_wr(3'h6, 8'h00);
    check("p4 drive", 8'h04, {2'b00, p4_drv});
    @(posedge clk) te <= 1'b0;
    bus_wr(3'h5, 8'h00);
    check("p4 drive", 8'h00, {2'b00, p4_drv});
    // receive inversion while the line idles
    bus_wr(3'h6, 8'h00);
    check("rx data", 8'h01, {7'h00, rxd});
    bus_wr(3'h6, 8'h04);
    check("rx data", 8'h00, {7'h00, rxd});
    // running receiver takes bit1 away from general I/O
    bus_wr(3'h5, 8'h02);
    check("p4 drive", 8'h02, {2'b00, p4_drv});
    @(posedge clk) re <= 1'b1;
    #1;
    check("p4 drive", 8'h00, {2'b00, p4_drv});
    @(posedge clk) re <= 1'b0;
    bus_wr(3'h5, 8'h00);
    // interrupt input select
    bus_wr(3'h7, 8'h01);
    check("int line", 8'h01, {7'h00, int_n});
    @(posedge clk) p4_ext <= 4'h2;
    #1;
    check("int line", 8'h00, {7'h00, int_n});
    bus_wr(3'h7, 8'h00);
    check("int line", 8'h01, {7'h00, int_n});
    // second reset in mid-run
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    bus_rd(3'h6, d);
    check("serial ctrl", 8'hc0, d);
    check("p3 pullups", 8'h00, {1'b0, p3_pu});
    report_and_stop();
  end
endmodule : test_port_pin_mux_serial_invert

`default_nettype wire
